// file: hw/pvc_regs.sv
// Purpose: vendor configuration and resolved-mode status registers of a PHY
// Assumes: 25 MHz clk, synchronous active-high reset held 3 or more edges
// Notes:   read data valid the cycle after the read strobe
//
// Function
// - at reset load the reduced-interface select from the strap pin level
// - force bit set reports good 100 Mbps link regardless of line
// - speed LED disable drives signal detect onto the speed LED output
// - collision select 0 shows duplex; 1 shows full duplex or collision
// - automatic power reduction only while enable bit is 1; resets to 1
// - writing 1 to state-machine reset resets every state machine
// - state-machine reset bit clears itself once the reset completes
// - preamble suppression bit is read/write, reset value 0
// - writing 1 to sleep powers down all but oscillator and clocks
// - clearing sleep restores prior configuration and resets state machines
// - remote loopout sends received data back out on transmit
// - on negotiation done set fast full-duplex bit for that mode
// - on negotiation done set fast half-duplex bit for that mode
// - on negotiation done set slow full-duplex bit for that mode
// - on negotiation done set slow half-duplex bit for that mode
`timescale 1ns/1ns
`include "pvc_map.svh"

module pvc_regs #(
  parameter int SMR_CYC   = `PVC_SMR_CYC,
  parameter int DATA_W    = 4
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // register port
  input  wire logic [`PVC_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  // strap pin
  input  wire logic                   rmii_strap_pin,
  // negotiation results
  input  wire logic                   an_done,
  input  wire logic                   an_speed_100,
  input  wire logic                   an_full_duplex,
  // line status
  input  wire logic                   line_link_100,
  input  wire logic                   signal_detect,
  input  wire logic                   collision,
  input  wire logic                   cable_idle,
  // receive data for loopout
  input  wire logic [DATA_W-1:0]      rx_data,
  input  wire logic                   rx_valid,
  // controls out
  output logic                        reduced_mii_select,
  output logic                        link_good_100,
  output logic                        speed_indicator_out,
  output logic                        duplex_collision_indicator_out,
  output logic                        power_reduce_active,
  output logic                        mgmt_preamble_suppress,
  output logic                        sleep_power_down,
  output logic                        state_machine_reset,
  // loopout transmit
  output logic      [DATA_W-1:0]      loop_tx_data,
  output logic                        loop_tx_valid
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic hit(input logic [`PVC_ADDR_W-1:0] a,
                               input logic [`PVC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic strap_sync;
  logic wr_cfg;
  logic rd_cfg;
  logic rd_stat;

  // strap crosses into clk
  pvc_sync u_strap (
    .clk   (clk),
    .d_in  (rmii_strap_pin),
    .q_out (strap_sync)
  );

  // strobes qualified by address
  assign wr_cfg  = reg_wr & hit(reg_addr, `PVC_OFF_CFG);
  assign rd_cfg  = reg_rd & hit(reg_addr, `PVC_OFF_CFG);
  assign rd_stat = reg_rd & hit(reg_addr, `PVC_OFF_STAT);

  // ****************************************************************
  // configuration bits
  // ****************************************************************
  logic rmii_r;
  logic flink_r;
  logic spled_r;
  logic colled_r;
  logic rpd_r;
  logic pre_r;
  logic loop_r;
  pvc_pkg::pvc_state_t state_r; // read by the write gates below

  // strap sampled while reset is held; frozen while asleep
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rmii_r <= strap_sync;
    end else if (wr_cfg && state_r != pvc_pkg::PVC_SLEEP) begin
      rmii_r <= reg_wdata[`PVC_CFG_RMII];
    end
  end

  // plain read/write controls; frozen while asleep so they survive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flink_r  <= `PVC_RST_FLINK;
      spled_r  <= `PVC_RST_SPLED;
      colled_r <= `PVC_RST_COLLED;
      rpd_r    <= `PVC_RST_RPD;
      pre_r    <= `PVC_RST_PRE;
      loop_r   <= `PVC_RST_LOOP;
    end else if (wr_cfg && state_r != pvc_pkg::PVC_SLEEP) begin
      flink_r  <= reg_wdata[`PVC_CFG_FLINK];
      spled_r  <= reg_wdata[`PVC_CFG_SPLED];
      colled_r <= reg_wdata[`PVC_CFG_COLLED];
      rpd_r    <= reg_wdata[`PVC_CFG_RPD];
      pre_r    <= reg_wdata[`PVC_CFG_PRE];
      loop_r   <= reg_wdata[`PVC_CFG_LOOP];
    end
  end

  // ****************************************************************
  // sleep and state-machine reset controller
  // ****************************************************************
  pvc_pkg::pvc_state_t state_nxt;
  logic [7:0]          cnt_r;
  logic [7:0]          cnt_nxt;
  logic                wr_smr;
  logic                wr_sleep;
  logic                cnt_done;

  assign wr_smr   = wr_cfg & reg_wdata[`PVC_CFG_SMR];
  assign wr_sleep = wr_cfg & reg_wdata[`PVC_CFG_SLEEP];
  assign cnt_done = (cnt_r == 8'(SMR_CYC - 1));

  // next state and reset counter
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      pvc_pkg::PVC_RUN: begin
        if (wr_sleep) begin
          state_nxt = pvc_pkg::PVC_SLEEP;
        end else if (wr_smr) begin
          state_nxt = pvc_pkg::PVC_SMR;
          cnt_nxt   = 8'h00;
        end
      end
      pvc_pkg::PVC_SLEEP: begin
        if (wr_cfg && !wr_sleep) begin
          state_nxt = pvc_pkg::PVC_SMR;
          cnt_nxt   = 8'h00;
        end
      end
      pvc_pkg::PVC_SMR: begin
        if (wr_sleep) begin
          state_nxt = pvc_pkg::PVC_SLEEP;
        end else if (wr_smr) begin
          cnt_nxt = 8'h00; // a new request restarts the reset
        end else if (cnt_done) begin
          state_nxt = pvc_pkg::PVC_RUN;
        end else begin
          cnt_nxt = cnt_r + 8'h01;
        end
      end
      default: begin
        state_nxt = pvc_pkg::PVC_RUN;
        cnt_nxt   = 8'h00;
      end
    endcase
  end

  // controller state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= pvc_pkg::PVC_RUN;
      cnt_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ****************************************************************
  // resolved-mode result bits
  // ****************************************************************
  logic [3:0]        res_r;
  logic [3:0]        res_nxt;
  pvc_pkg::pvc_mode_t mode;

  assign mode = pvc_pkg::pvc_mode_t'({an_speed_100, an_full_duplex});

  // one-hot decode of the resolved mode
  generate
    for (genvar i = 0; i < 4; i++) begin : g_res
      assign res_nxt[i] = (mode == pvc_pkg::pvc_mode_t'(i));
    end
  endgenerate

  // captured on completion, held otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_r <= `PVC_RST_RES;
    end else if (an_done) begin
      res_r <= res_nxt;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [15:0] cfg_view;
  logic [15:0] stat_view;

  // register images; uncovered bits read zero
  always_comb begin
    cfg_view = 16'h0000;
    cfg_view[`PVC_CFG_RMII]   = rmii_r;
    cfg_view[`PVC_CFG_FLINK]  = flink_r;
    cfg_view[`PVC_CFG_SPLED]  = spled_r;
    cfg_view[`PVC_CFG_COLLED] = colled_r;
    cfg_view[`PVC_CFG_RPD]    = rpd_r;
    cfg_view[`PVC_CFG_SMR]    = (state_r == pvc_pkg::PVC_SMR);
    cfg_view[`PVC_CFG_PRE]    = pre_r;
    cfg_view[`PVC_CFG_SLEEP]  = (state_r == pvc_pkg::PVC_SLEEP);
    cfg_view[`PVC_CFG_LOOP]   = loop_r;
    stat_view = 16'h0000;
    stat_view[`PVC_ST_RES_MSB:`PVC_ST_RES_LSB] = res_r;
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (rd_cfg) begin
      reg_rdata <= cfg_view;
    end else if (rd_stat) begin
      reg_rdata <= stat_view;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************************************
  // control outputs
  // ****************************************************************
  logic asleep;

  assign asleep = (state_r == pvc_pkg::PVC_SLEEP);

  // steering of link, LEDs and power
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reduced_mii_select             <= 1'h0;
      link_good_100                  <= 1'h0;
      speed_indicator_out            <= 1'h0;
      duplex_collision_indicator_out <= 1'h0;
      power_reduce_active            <= 1'h0;
      mgmt_preamble_suppress         <= 1'h0;
      sleep_power_down               <= 1'h0;
      state_machine_reset            <= 1'h0;
    end else begin
      reduced_mii_select             <= rmii_r;
      link_good_100                  <= flink_r | line_link_100;
      speed_indicator_out            <= spled_r ? signal_detect : an_speed_100;
      duplex_collision_indicator_out <= colled_r ? (an_full_duplex | collision)
                                                 : an_full_duplex;
      power_reduce_active            <= rpd_r & cable_idle & ~asleep;
      mgmt_preamble_suppress         <= pre_r;
      sleep_power_down               <= (state_nxt == pvc_pkg::PVC_SLEEP);
      state_machine_reset            <= (state_nxt == pvc_pkg::PVC_SMR);
    end
  end

  // loopout of received data onto transmit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loop_tx_data  <= '0;
      loop_tx_valid <= 1'h0;
    end else begin
      loop_tx_data  <= (loop_r && !asleep) ? rx_data : '0;
      loop_tx_valid <= loop_r & rx_valid & ~asleep;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_force_link: assert property (
    @(posedge clk) disable iff (sys_rst) flink_r |=> link_good_100)
    else $error("forced link not reported");

  a_speed_led_mux: assert property (
    @(posedge clk) disable iff (sys_rst)
    spled_r |=> (speed_indicator_out == $past(signal_detect)))
    else $error("speed led not showing signal detect");

  a_dup_led_mux: assert property (
    @(posedge clk) disable iff (sys_rst)
    !colled_r |=> (duplex_collision_indicator_out == $past(an_full_duplex)))
    else $error("duplex led not showing duplex only");

  a_power_gate: assert property (
    @(posedge clk) disable iff (sys_rst) !rpd_r |=> !power_reduce_active)
    else $error("power reduction while disabled");

  a_smr_start: assert property (
    @(posedge clk) disable iff (sys_rst)
    (state_r == pvc_pkg::PVC_RUN && wr_smr && !wr_sleep) |=> state_machine_reset)
    else $error("state machine reset not started");

  logic [7:0] smr_age_r;
  // cycles the reset output has stood since the last config write
  always_ff @(posedge clk) begin
    if (sys_rst || wr_cfg || !state_machine_reset) begin
      smr_age_r <= 8'h00;
    end else begin
      smr_age_r <= smr_age_r + 8'h01;
    end
  end

  a_smr_clears: assert property (
    @(posedge clk) disable iff (sys_rst) smr_age_r <= 8'(SMR_CYC))
    else $error("state machine reset never completes");

  a_sleep_enter: assert property (
    @(posedge clk) disable iff (sys_rst) wr_sleep |=> sleep_power_down)
    else $error("sleep not entered");

  a_wake_reset: assert property (
    @(posedge clk) disable iff (sys_rst)
    (asleep && wr_cfg && !wr_sleep) |=> (state_machine_reset && !sleep_power_down))
    else $error("wake did not reset state machines");

  a_wake_keeps: assert property (
    @(posedge clk) disable iff (sys_rst)
    asleep |=> ($stable(loop_r) && $stable(rpd_r) && $stable(flink_r) && $stable(rmii_r)))
    else $error("configuration changed during sleep");

  a_loop_data: assert property (
    @(posedge clk) disable iff (sys_rst)
    (loop_r && !asleep) |=> (loop_tx_data == $past(rx_data)))
    else $error("loopout data mismatch");

  a_res_onehot: assert property (
    @(posedge clk) disable iff (sys_rst)
    an_done |=> ($onehot(res_r) && res_r[$past(mode)]))
    else $error("result bits not one-hot for resolved mode");

  a_pre_reads: assert property (
    @(posedge clk) disable iff (sys_rst)
    rd_cfg |=> (reg_rdata[`PVC_CFG_PRE] == mgmt_preamble_suppress))
    else $error("preamble bit readback mismatch");

endmodule : pvc_regs

// file: hw/pvc_sync.sv
// Purpose: two flip-flop synchroniser for one level from a pin
// Assumes: input is asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns

module pvc_sync (
  // clock
  input  wire logic clk,
  // level
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_r;

  // two-stage capture
  always_ff @(posedge clk) begin
    meta_r <= d_in;
    q_out  <= meta_r;
  end

endmodule : pvc_sync

// file: shared/pvc_map.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 16-bit management registers at their printed offsets
// Notes:   definitions only
`ifndef PVC_MAP_SVH
`define PVC_MAP_SVH

// ****************************************************************
// offsets
// ****************************************************************
`define PVC_ADDR_W        5
`define PVC_OFF_CFG       5'h10
`define PVC_OFF_STAT      5'h11

// ****************************************************************
// configuration register fields
// ****************************************************************
`define PVC_CFG_RMII      8
`define PVC_CFG_FLINK     7
`define PVC_CFG_SPLED     6
`define PVC_CFG_COLLED    5
`define PVC_CFG_RPD       4
`define PVC_CFG_SMR       3
`define PVC_CFG_PRE       2
`define PVC_CFG_SLEEP     1
`define PVC_CFG_LOOP      0

// ****************************************************************
// status register fields
// ****************************************************************
`define PVC_ST_RES_LSB    12
`define PVC_ST_RES_MSB    15

// ****************************************************************
// reset values
// ****************************************************************
`define PVC_RST_FLINK     1'h0
`define PVC_RST_SPLED     1'h0
`define PVC_RST_COLLED    1'h0
`define PVC_RST_RPD       1'h1
`define PVC_RST_PRE       1'h0
`define PVC_RST_SLEEP     1'h0
`define PVC_RST_LOOP      1'h0
`define PVC_RST_RES       4'hF

// ****************************************************************
// timing
// ****************************************************************
`define PVC_CLK_MHZ       25
`define PVC_SMR_NS        160
`define PVC_SMR_CYC       ((`PVC_SMR_NS * `PVC_CLK_MHZ + 999) / 1000)

`endif

// file: shared/pvc_pkg.sv
// Purpose: shared types of the vendor configuration/status block
// Assumes: constants live in pvc_map.svh
// Notes:   controller state codes; sleep is one bit from run and from reset
package pvc_pkg;

  // controller states, one bit apart along run -> sleep -> reset; reset -> run flips both bits
  typedef enum logic [1:0] {
    PVC_RUN   = 2'h0,
    PVC_SLEEP = 2'h1,
    PVC_SMR   = 2'h3
  } pvc_state_t;

  // index of a resolved mode in the four result bits
  typedef enum logic [1:0] {
    PVC_M10H  = 2'h0,
    PVC_M10F  = 2'h1,
    PVC_M100H = 2'h2,
    PVC_M100F = 2'h3
  } pvc_mode_t;

endpackage : pvc_pkg

// file: verification/pvc_mgmt_model.sv
// Purpose: management-side master driving the register port
// Assumes: one clock; slave never stalls; read data stand one cycle
// Notes:   released address/data show the inverted last value
`timescale 1ns/1ns
`include "pvc_map.svh"

module pvc_mgmt_model (
  // clock
  input  wire logic                   clk,
  // register port
  output logic      [`PVC_ADDR_W-1:0] reg_addr,
  output logic      [15:0]            reg_wdata,
  output logic                        reg_wr,
  output logic                        reg_rd,
  input  wire logic [15:0]            reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one write cycle, strobe beside address and data
  task automatic wr(input logic [`PVC_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // one read cycle, data taken at the end of the next cycle
  task automatic rd(input logic [`PVC_ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : pvc_mgmt_model

// file: verification/tb.sv
// Purpose: self-checking bench for the vendor config/status registers
// Assumes: 25 MHz clock, synchronous reset held 8 cycles
// Notes:   outputs sampled at clock edges, before that edge's updates
`timescale 1ns/1ns
`include "pvc_map.svh"

module tb;
  localparam int SMC = 8;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic                   clk = 1'b0, sys_rst = 1'b1;
  logic [`PVC_ADDR_W-1:0] reg_addr;
  logic [15:0]            reg_wdata, reg_rdata;
  logic                   reg_wr, reg_rd;
  logic                   strap = 1'b1, an_done = 1'b0;
  logic                   an_speed_100 = 1'b0, an_full_duplex = 1'b0;
  logic                   line_link_100 = 1'b0, signal_detect = 1'b1;
  logic                   collision = 1'b1, cable_idle = 1'b1;
  logic [3:0]             rx_data = 4'hA, loop_tx_data;
  logic                   rx_valid = 1'b1, loop_tx_valid;
  logic                   rmii_sel, link_good, spd_led, dup_led, pwr_red;
  logic                   pre_sup, sleep_pd, smr;
  int                     err_count = 0, cmp_count = 0;

  // clock
  always #20 clk = ~clk;

  // design and management master
  pvc_regs #(.SMR_CYC(SMC), .DATA_W(4)) uut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rmii_strap_pin(strap), .an_done(an_done), .an_speed_100(an_speed_100),
    .an_full_duplex(an_full_duplex), .line_link_100(line_link_100),
    .signal_detect(signal_detect), .collision(collision), .cable_idle(cable_idle),
    .rx_data(rx_data), .rx_valid(rx_valid), .reduced_mii_select(rmii_sel),
    .link_good_100(link_good), .speed_indicator_out(spd_led),
    .duplex_collision_indicator_out(dup_led), .power_reduce_active(pwr_red),
    .mgmt_preamble_suppress(pre_sup), .sleep_power_down(sleep_pd),
    .state_machine_reset(smr), .loop_tx_data(loop_tx_data),
    .loop_tx_valid(loop_tx_valid));
  pvc_mgmt_model mgr (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // wait for the reset sequence to finish, bounded
  task automatic wait_smr;
    for (int n = 0; n < 4 * SMC && smr !== 1'b0; n++) @(posedge clk);
  endtask : wait_smr

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [15:0] d;
    mgr.wr(5'h12, 16'hFFFF);
    mgr.wr(`PVC_OFF_STAT, 16'hFFFF);
    mgr.rd(`PVC_OFF_CFG, d);
    chk(d, 16'h0110);
    chk(rmii_sel, 1'b1);
    chk(pwr_red, 1'b1);
    mgr.rd(5'h12, d);
    chk(d, 16'h0000);
    mgr.rd(`PVC_OFF_STAT, d);
    chk(d, 16'hF000);
    $display("reset values done");
  endtask : t_reset

  task automatic t_fields;
    logic [15:0] d, w;
    logic        b;
    for (int i = 1; i >= 0; i--) begin
      b = i[0];
      w = b ? 16'h00E5 : 16'h0110;
      rx_data <= b ? 4'hA : 4'h5;
      mgr.wr(`PVC_OFF_CFG, w);
      mgr.rd(`PVC_OFF_CFG, d);
      chk(d, w);
      chk(rmii_sel, !b);
      chk(link_good, b);
      chk(spd_led, b);
      chk(dup_led, b);
      chk(pwr_red, !b);
      chk(pre_sup, b);
      chk({loop_tx_valid, loop_tx_data}, b ? 5'h1A : 5'h00);
    end
    $display("control fields done");
  endtask : t_fields

  task automatic t_smr;
    logic [15:0] d;
    mgr.wr(`PVC_OFF_CFG, 16'h0118);
    mgr.rd(`PVC_OFF_CFG, d);
    chk(d, 16'h0118);
    chk(smr, 1'b1);
    wait_smr();
    chk(smr, 1'b0);
    mgr.rd(`PVC_OFF_CFG, d);
    chk(d, 16'h0110);
    $display("state machine reset done");
  endtask : t_smr

  task automatic t_sleep;
    logic [15:0] d;
    mgr.wr(`PVC_OFF_CFG, 16'h0114);
    mgr.wr(`PVC_OFF_CFG, 16'h0116);
    mgr.rd(`PVC_OFF_CFG, d);
    chk(d, 16'h0116);
    chk(sleep_pd, 1'b1);
    chk(pwr_red, 1'b0);
    // other bits written while asleep must be dropped
    mgr.wr(`PVC_OFF_CFG, 16'h00E3);
    mgr.wr(`PVC_OFF_CFG, 16'h0000);
    mgr.rd(`PVC_OFF_CFG, d);
    chk(d, 16'h011C);
    chk(sleep_pd, 1'b0);
    chk(smr, 1'b1);
    wait_smr();
    mgr.rd(`PVC_OFF_CFG, d);
    chk(d, 16'h0114);
    chk(pre_sup, 1'b1);
    mgr.wr(`PVC_OFF_CFG, 16'h0110);
    $display("sleep and wake done");
  endtask : t_sleep

  task automatic t_results;
    logic [15:0] d;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      an_speed_100   <= k[1];
      an_full_duplex <= k[0];
      an_done        <= 1'b1;
      @(posedge clk);
      an_done        <= 1'b0;
      an_speed_100   <= ~k[1];
      // result bits read only after negotiation completed
      mgr.rd(`PVC_OFF_STAT, d);
      chk(d, 16'h1000 << k);
    end
    $display("negotiation results done");
  endtask : t_results

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_fields();
    t_smr();
    t_sleep();
    t_results();
    give_verdict();
  end

  // cut a hang short at 4000 cycles, well past the expected hundred or so cycles
  initial begin
    #(40 * 4000);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : tb
